// ==== logic/led_scan_core.sv ====
`timescale 1ns/1ps
`include "led_scan_regs.svh"

module led_scan_core import led_scan_pkg::*; #(
  parameter int BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register writes from the serial front end
  input wire logic wr_stb,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // register reads
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // levels from the shutdown and blink control registers
  input wire logic shutdown,
  input wire logic blink_fast_sel,
  // display drive
  output logic [3:0] digit_on,
  output logic [2:0] scan_slot,
  output logic test_active,
  output logic blink_clk
);

  // ****************************************************************
  // constants at the width of what they meet
  // ****************************************************************
  localparam logic [7:0] TICK_LAST = 8'(`STEP_CYCLES - 1);
  localparam logic [23:0] BLINK_LAST = 24'(BLINK_HALF_CYCLES - 1);

  scan_state_t q;
  scan_state_t n;
  logic [3:0] dig_lit;
  logic tick_end;
  logic boundary;
  scan_mode_t mode_next;

  // ****************************************************************
  // duty helpers
  // ****************************************************************

  // code 15 is held to 14 so the last step of a phase always stays dark
  function automatic logic [3:0] eff_code(input logic [3:0] code);
    eff_code = (code == `CODE_TOP) ? `CODE_CAPPED : code;
  endfunction : eff_code

  // pick the nibble that feeds digit d from the latched brightness pair
  function automatic logic [3:0] nib_of(input logic [7:0] lo,
                                        input logic [7:0] hi,
                                        input int d);
    logic [7:0] src;
    src = (d >= 2) ? hi : lo;
    if (d % 2 == 0) begin
      nib_of = src[`EVEN_NIB_LSB +: 4];
    end else begin
      nib_of = src[`ODD_NIB_LSB +: 4];
    end
  endfunction : nib_of

  // ****************************************************************
  // per-digit pulse-width modulators
  // ****************************************************************

  // each digit compares the shared step count to its own code; a digit
  // lights only while its pair owns the current slot
  for (genvar d = 0; d < 4; d++) begin : g_pwm
    logic pair_owns;
    logic [3:0] code;
    // digits 0 and 1 own slot bit 0 clear, digits 2 and 3 own it set
    assign pair_owns = (q.slot[0] == (d >= 2));
    assign code = (q.mode == MODE_TEST) ? `TEST_CODE
                : eff_code(nib_of(q.cur_lo, q.cur_hi, d));
    // test overrides shutdown; otherwise shutdown blanks the digit
    assign dig_lit[d] = pair_owns
                      && (q.step <= code)
                      && ((q.mode == MODE_TEST) || !shutdown);
  end

  // ****************************************************************
  // scan timing
  // ****************************************************************

  // a phase is sixteen steps; the boundary is the last tick of step 15
  assign tick_end = (q.tick == TICK_LAST);
  assign boundary = tick_end && (q.step == `STEPS_LAST);

  // mode for the next phase, taken from the registers as they stand
  always_comb begin
    if (q.test_sel[`TEST_BIT]) begin
      mode_next = MODE_TEST;
    end else if (q.scan_lim[`LIM_BIT]) begin
      mode_next = MODE_BOTH;
    end else begin
      mode_next = MODE_PAIR0;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = q;

    // step and tick counters
    if (tick_end) begin
      n.tick = 8'h00;
      n.step = q.step + 4'h1;
    end else begin
      n.tick = q.tick + 8'h01;
    end

    // settings move into the working copy only between phases, so no
    // register write ever cuts a digit's pulse short; shutdown still can
    if (boundary) begin
      n.mode = mode_next;
      n.cur_lo = q.bright_lo;
      n.cur_hi = q.bright_hi;
      unique case (mode_next)
        MODE_TEST: begin
          // eight slots; slot bit 0 still picks the pair
          n.slot = (q.slot == `TEST_SLOT_LAST) ? 3'h0
                 : q.slot + 3'h1;
        end
        MODE_BOTH: begin
          n.slot = {2'b00, ~q.slot[0]};
        end
        MODE_PAIR0: begin
          n.slot = 3'h0;
        end
      endcase
    end

    // register writes; test mode reads these but never alters them
    if (wr_stb) begin
      unique case (wr_addr)
        `ADDR_BRIGHT_LO: n.bright_lo = wr_data;
        `ADDR_BRIGHT_HI: n.bright_hi = wr_data;
        `ADDR_SCAN_LIM: n.scan_lim = wr_data;
        `ADDR_TEST_SEL: n.test_sel = wr_data;
        default: begin
        end
      endcase
    end

    // register reads answer one cycle after the address is presented
    unique case (rd_addr)
      `ADDR_BRIGHT_LO: n.rd_data = q.bright_lo;
      `ADDR_BRIGHT_HI: n.rd_data = q.bright_hi;
      `ADDR_SCAN_LIM: n.rd_data = q.scan_lim;
      `ADDR_TEST_SEL: n.rd_data = q.test_sel;
      default: n.rd_data = `UNMAPPED_READ;
    endcase

    // drive lags the counters by one cycle, which keeps duty exact
    n.digit_on = dig_lit;

    // blink divider: fast toggles every half second, slow divides fast
    if (q.blink_cnt == BLINK_LAST) begin
      n.blink_cnt = 24'h00_0000;
      n.blink_fast = ~q.blink_fast;
      if (q.blink_fast) begin
        n.blink_slow = ~q.blink_slow;
      end
    end else begin
      n.blink_cnt = q.blink_cnt + 24'h00_0001;
    end
    n.blink_out = blink_fast_sel ? q.blink_fast : q.blink_slow;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      q.bright_lo <= `REG_RESET;
      q.bright_hi <= `REG_RESET;
      q.scan_lim <= `REG_RESET;
      q.test_sel <= `REG_RESET;
      q.rd_data <= `UNMAPPED_READ;
      q.cur_lo <= `REG_RESET;
      q.cur_hi <= `REG_RESET;
      q.mode <= MODE_PAIR0;
      q.slot <= 3'h0;
      q.step <= 4'h0;
      q.tick <= 8'h00;
      q.digit_on <= 4'h0;
      q.blink_cnt <= 24'h00_0000;
      q.blink_fast <= 1'b0;
      q.blink_slow <= 1'b0;
      q.blink_out <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // outputs, all straight from the state register
  // ****************************************************************
  assign rd_data = q.rd_data;
  assign digit_on = q.digit_on;
  assign scan_slot = q.slot;
  assign test_active = q.mode[2]; // one-hot bit of the test mode
  assign blink_clk = q.blink_out;

endmodule : led_scan_core

// ==== logic/led_scan_regs.svh ====
`ifndef LED_SCAN_REGS_SVH
`define LED_SCAN_REGS_SVH

// ****************************************************************
// register offsets and reset values
// ****************************************************************
`define ADDR_BRIGHT_LO 8'h01
`define ADDR_BRIGHT_HI 8'h02
`define ADDR_SCAN_LIM 8'h03
`define ADDR_TEST_SEL 8'h07
`define REG_RESET 8'h00
`define UNMAPPED_READ 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define LIM_BIT 0
`define TEST_BIT 0
`define EVEN_NIB_LSB 0
`define ODD_NIB_LSB 4

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 50
`define CLK_KHZ 20000
`define PWM_STEP_NS 200
`define STEP_CYCLES ((`PWM_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEPS_LAST 4'hF
`define CODE_TOP 4'hF
`define CODE_CAPPED 4'hE
`define TEST_CODE 4'h6
`define TEST_SLOT_LAST 3'h7
`define BLINK_FAST_PERIOD_MS 1000
`define BLINK_SLOW_PERIOD_MS 2000
`define BLINK_HALF_CYCLES (`CLK_KHZ * `BLINK_FAST_PERIOD_MS / 2)

`endif

// ==== logic/led_scan_pkg.sv ====
package led_scan_pkg;

  // ****************************************************************
  // scan modes
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_PAIR0 = 3'b001,
    MODE_BOTH = 3'b010,
    MODE_TEST = 3'b100
  } scan_mode_t;

  // ****************************************************************
  // whole state of the block
  // ****************************************************************
  typedef struct packed {
    logic [7:0] bright_lo;
    logic [7:0] bright_hi;
    logic [7:0] scan_lim;
    logic [7:0] test_sel;
    logic [7:0] rd_data;
    logic [7:0] cur_lo;
    logic [7:0] cur_hi;
    scan_mode_t mode;
    logic [2:0] slot;
    logic [3:0] step;
    logic [7:0] tick;
    logic [3:0] digit_on;
    logic [23:0] blink_cnt;
    logic blink_fast;
    logic blink_slow;
    logic blink_out;
  } scan_state_t;

endpackage : led_scan_pkg

// ==== bench/led_scan_core_properties.sv ====
`timescale 1ns/1ps
// ****
// port checks of the scan block
// ****
module led_scan_checker import led_scan_pkg::*; #(
  parameter int BLINK_HALF_CYCLES = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // read port
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // levels and drive
  input wire logic shutdown,
  input wire logic blink_fast_sel,
  input wire logic [3:0] digit_on,
  input wire logic [2:0] scan_slot,
  input wire logic test_active,
  input wire logic blink_clk
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // blink gap below assumes eight clocks per half period in the bench
  sequence s_quiet;
    $stable(blink_clk) && $stable(blink_fast_sel);
  endsequence
  sequence s_dark;
    (shutdown && !test_active) [*2];
  endsequence
  property p_pair; !(|digit_on[1:0] && |digit_on[3:2]); endproperty
  property p_off; $fell(digit_on[0]) |-> !digit_on[0] [*4]; endproperty
  // shutdown may cut a pulse short, so it excuses the minimum on-time
  property p_on;
    $rose(digit_on[0]) |-> (digit_on[0] [*4]) or (##[0:3] shutdown);
  endproperty
  property p_dark; s_dark |-> digit_on == 4'h0; endproperty
  property p_slot; !test_active [*2] |-> scan_slot[2:1] == 2'b00; endproperty
  property p_tstep;
    test_active && $past(test_active) && $changed(scan_slot)
      |-> scan_slot == $past(scan_slot) + 3'h1;
  endproperty
  property p_unmap;
    !(rd_addr inside {8'h01, 8'h02, 8'h03, 8'h07}) |=> rd_data == 8'h00;
  endproperty
  property p_blink;
    $changed(blink_clk) ##1 s_quiet [*6] ##1 $stable(blink_fast_sel)
      |-> $stable(blink_clk);
  endproperty
  // step 15 is always dark, so a mode or slot change mid-phase shows here
  property p_bound;
    ($changed(test_active) || $changed(scan_slot)) |-> digit_on == 4'h0;
  endproperty
  a_pair: assert property (p_pair) else $error("both pairs lit");
  a_off: assert property (p_off) else $error("off time short");
  a_on: assert property (p_on) else $error("on time short");
  a_dark: assert property (p_dark) else $error("lit in shutdown");
  a_slot: assert property (p_slot) else $error("slot out of range");
  a_tstep: assert property (p_tstep) else $error("test slot skip");
  a_unmap: assert property (p_unmap) else $error("unmapped not 0");
  a_blink: assert property (p_blink) else $error("blink too fast");
  a_bound: assert property (p_bound) else $error("mid-phase change");
endmodule : led_scan_checker

bind led_scan_core led_scan_checker #(
  .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) u_chk (.clock(clock), .rst(rst), .rd_addr(rd_addr), .rd_data(rd_data),
  .shutdown(shutdown), .blink_fast_sel(blink_fast_sel),
  .digit_on(digit_on), .scan_slot(scan_slot), .test_active(test_active),
  .blink_clk(blink_clk));

// ==== bench/host_write_model.sv ====
`timescale 1ns/1ps
// ****
// host side of the register write port
// ****
module host_write_model (
  // clock
  input wire logic clock,
  // write port
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  initial begin
    wr_stb = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
  end
  // address and data move together, so no half write can land
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    wr_stb = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clock);
    wr_stb = 1'b0;
    wr_addr = ~a; // released lines must not look valid
    wr_data = ~d;
  endtask : write
endmodule : host_write_model

// ==== bench/led_matrix_scan_test_intensity_test.sv ====
`timescale 1ns/1ps
`include "led_scan_regs.svh"
module led_matrix_scan_test_intensity_test;
  logic clock, rst, shutdown, blink_fast_sel, wr_stb, blink_clk, test_active;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  logic [3:0] digit_on;
  logic [2:0] scan_slot;
  int bad_count = 0;
  int compares = 0;
  int lit [4];
  int flips;
  host_write_model u_host (.clock(clock), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_data(wr_data));
  led_scan_core #(.BLINK_HALF_CYCLES(8)) u_dut (.clock(clock), .rst(rst),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .shutdown(shutdown),
    .blink_fast_sel(blink_fast_sel), .digit_on(digit_on),
    .scan_slot(scan_slot), .test_active(test_active), .blink_clk(blink_clk));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ****
  // tasks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    rd_addr = a;
    @(negedge clock);
    check(rd_data, exp);
  endtask : rd
  // lit clocks per digit and blink edges over n clocks; windows are whole
  // periods so the phase of the start does not matter
  task automatic measure(input int n);
    logic last;
    lit = '{0, 0, 0, 0};
    flips = 0;
    last = blink_clk;
    repeat (n) begin
      @(negedge clock);
      for (int d = 0; d < 4; d++) lit[d] += digit_on[d];
      flips += (blink_clk !== last);
      last = blink_clk;
    end
  endtask : measure
  task automatic lits(input int a, input int b, input int c, input int e);
    check(lit[0], a);
    check(lit[1], b);
    check(lit[2], c);
    check(lit[3], e);
  endtask : lits
  task automatic print_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #1_000_000;
    bad_count++;
    print_verdict();
  end
  // ****
  // tests; first measure of each pair only lets the phase boundary pass
  // ****
  initial begin
    rst = 1'b1;
    shutdown = 1'b0;
    blink_fast_sel = 1'b1;
    rd_addr = 8'h00;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    rd(`ADDR_BRIGHT_LO, 8'h00);
    rd(`ADDR_SCAN_LIM, 8'h00);
    rd(`ADDR_TEST_SEL, 8'h00);
    rd(8'h05, 8'h00);
    $display("test reset done");
    u_host.write(`ADDR_BRIGHT_LO, 8'hF3);
    u_host.write(`ADDR_BRIGHT_HI, 8'h7E);
    u_host.write(`ADDR_SCAN_LIM, 8'hFE);
    rd(`ADDR_SCAN_LIM, 8'hFE);
    measure(128);
    measure(128);
    // one pair only: every 64-clock phase belongs to digits 0 and 1
    lits(32, 120, 0, 0);
    check(flips, 16);
    check(scan_slot, 3'h0);
    $display("test two digits done");
    u_host.write(`ADDR_SCAN_LIM, 8'h01);
    blink_fast_sel = 1'b0;
    measure(128);
    measure(128);
    lits(16, 60, 60, 32);
    check(flips, 8);
    $display("test four digits done");
    shutdown = 1'b1;
    measure(128);
    lits(0, 0, 0, 0);
    u_host.write(`ADDR_TEST_SEL, 8'hFF);
    measure(128);
    measure(512);
    lits(112, 112, 112, 112);
    check(test_active, 1'b1);
    rd(`ADDR_BRIGHT_LO, 8'hF3);
    shutdown = 1'b0;
    u_host.write(`ADDR_TEST_SEL, 8'hFE);
    measure(128);
    measure(128);
    lits(16, 60, 60, 32);
    check(test_active, 1'b0);
    $display("test display test done");
    print_verdict();
  end
endmodule : led_matrix_scan_test_intensity_test
